/* File: slx_pkg.sv */
/*
  slx_pkg: constants and carrier types for the sixteen-bit load executor.
  assumes a single 40 MHz clock; no software-visible registers.
*/
package slx_pkg;
  localparam logic [7:0] PFX_IDX1     = 8'hDD; // first index prefix
  localparam logic [7:0] PFX_IDX2     = 8'hFD; // second index prefix
  localparam logic [7:0] PFX_EXT      = 8'hED; // extended prefix
  localparam logic [7:0] OPC_LDI_IDX  = 8'h21; // index load immediate
  localparam logic [7:0] OPC_LDM_HL   = 8'h2A; // pair/index load memory
  localparam logic [7:0] OPC_STM_HL   = 8'h22; // pair/index store memory
  localparam logic [7:0] MSK_LDI      = 8'hCF; // 00dd0001 pattern mask
  localparam logic [7:0] PAT_LDI      = 8'h01;
  localparam logic [7:0] PAT_EXT_LD   = 8'h4B; // 01dd1011
  localparam logic [7:0] PAT_EXT_ST   = 8'h43; // 01dd0011
  localparam int         SEL_LSB      = 4;     // pair field at bits 5:4
  localparam logic [1:0] SEL_FIRST    = 2'h0;
  localparam logic [1:0] SEL_SECOND   = 2'h1;
  localparam logic [1:0] SEL_THIRD    = 2'h2;
  localparam logic [1:0] SEL_STACK    = 2'h3;
  localparam logic [7:0] FLAGS_RST    = 8'h00;
  localparam logic [15:0] WORD_RST    = 16'h0000;
  // machine-cycle lengths in clock states
  localparam logic [2:0] T_FETCH      = 3'h4;
  localparam logic [2:0] T_MEM        = 3'h3;

  typedef enum logic [5:0] {
    SLX_FETCH = 6'b000001, // opcode or prefix fetch, 4 states
    SLX_OPLO  = 6'b000010, // operand low byte read
    SLX_OPHI  = 6'b000100, // operand high byte read
    SLX_MEMLO = 6'b001000, // data low byte at address
    SLX_MEMHI = 6'b010000, // data high byte at address+1
    SLX_DONE  = 6'b100000  // one-cycle completion
  } slx_state_t;

  typedef enum logic [2:0] {
    SLX_K_IMM = 3'h0, SLX_K_LOAD = 3'h1, SLX_K_STORE = 3'h2,
    SLX_K_NONE = 3'h3
  } slx_kind_t;

  typedef enum logic [2:0] {
    SLX_D_FIRST = 3'h0, SLX_D_SECOND = 3'h1, SLX_D_THIRD = 3'h2,
    SLX_D_STACK = 3'h3, SLX_D_IDX1 = 3'h4, SLX_D_IDX2 = 3'h5
  } slx_dest_t;

  // register bank carried as one unit
  typedef struct packed {
    logic [15:0] first_pair;
    logic [15:0] second_pair;
    logic [15:0] third_pair;
    logic [15:0] stack_pointer;
    logic [15:0] index_reg_first;
    logic [15:0] index_reg_second;
  } slx_regs_t;

  // memory cycle request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } slx_mem_t;
endpackage

/* File: slx_exec.sv */
/*
  slx_exec: decodes and runs the sixteen-bit load group of the cpu core:
  immediate loads of pairs and index registers, loads of pairs and index
  registers from a memory word, and stores of them to a memory word.
  one machine cycle at a time: fetch 4 states, operand and data reads or
  writes 3 states each; the register bank changes only at the last state.
  assumes memory answers MEM_RDATA at the last state of each read cycle
  and that opcode bytes come through the same memory port at PC.
  assumes START is a one-cycle request given only while BUSY is low, and
  that the core merges FLAGS_OUT back untouched: this group sets no flag.
  stack-pointer transfers, push, pop and the second index store are not
  here; they come back as ILLEGAL for the core to run.
*/
// Function
// - load-immediate-pair puts operand word into the pair chosen by bits 5:4
// - pair field: 00 first, 01 second, 10 third, 11 stack pointer
// - first operand byte is the low byte, second the high byte
// - load-immediate-pair takes 10 states: 4, 3, 3
// - prefix DD, 21 loads first index immediately in 14 states 4,4,3,3
// - prefix FD, 21 loads second index with the same timing
// - 2A loads third pair low from address, high from address+1, 16 states
// - ED 01dd1011 loads chosen pair from address and address+1, 20 states
// - DD 2A loads first index from address and address+1, 20 states
// - FD 2A loads second index from address and address+1, 20 states
// - 22 stores third pair low at address, high at address+1, 16 states
// - ED 01dd0011 stores chosen pair low then high, 20 states
// - DD 22 stores first index low at address, high at address+1
// - no instruction in this group alters a condition flag
`timescale 1ns/1ps
`default_nettype none
module slx_exec (
  input  wire logic              MCLK,
  input  wire logic              RESET,
  input  wire logic              START,
  input  wire logic [15:0]       PC_IN,
  input  wire logic [7:0]        MEM_RDATA,
  input  wire logic [7:0]        FLAGS_IN,
  output logic                   MEM_RD,
  output logic                   MEM_WR,
  output logic [15:0]            MEM_ADDR,
  output logic [7:0]             MEM_WDATA,
  output logic                   BUSY,
  output logic                   DONE,
  output logic                   ILLEGAL,
  output logic [7:0]             FLAGS_OUT,
  output slx_pkg::slx_regs_t     REGS
);
  typedef struct packed {
    slx_pkg::slx_state_t st;
    logic [2:0]          tcnt;
    logic [15:0]         pc;
    logic [7:0]          prefix;
    slx_pkg::slx_kind_t  kind;
    slx_pkg::slx_dest_t  dest;
    logic [15:0]         oper;
    logic [7:0]          lo_byte;
    slx_pkg::slx_regs_t  regs;
    slx_pkg::slx_mem_t   mem;
    logic                busy;
    logic                done;
    logic                illegal;
    logic [7:0]          flags;
  } slx_all_t;

  slx_all_t s_ff;
  slx_all_t nxt_s;

  // pair field to destination code
  function automatic slx_pkg::slx_dest_t pair_dest(input logic [7:0] op);
    logic [1:0] f;
    f = op[slx_pkg::SEL_LSB +: 2];
    case (f)
      slx_pkg::SEL_FIRST:  pair_dest = slx_pkg::SLX_D_FIRST;
      slx_pkg::SEL_SECOND: pair_dest = slx_pkg::SLX_D_SECOND;
      slx_pkg::SEL_THIRD:  pair_dest = slx_pkg::SLX_D_THIRD;
      default:             pair_dest = slx_pkg::SLX_D_STACK;
    endcase
  endfunction

  // read the register that a destination code names
  function automatic logic [15:0] get_reg(input slx_pkg::slx_regs_t r,
                                          input slx_pkg::slx_dest_t d);
    case (d)
      slx_pkg::SLX_D_FIRST:  get_reg = r.first_pair;
      slx_pkg::SLX_D_SECOND: get_reg = r.second_pair;
      slx_pkg::SLX_D_THIRD:  get_reg = r.third_pair;
      slx_pkg::SLX_D_STACK:  get_reg = r.stack_pointer;
      slx_pkg::SLX_D_IDX1:   get_reg = r.index_reg_first;
      default:               get_reg = r.index_reg_second;
    endcase
  endfunction

  // write one register, leave the rest
  function automatic slx_pkg::slx_regs_t put_reg(
      input slx_pkg::slx_regs_t r, input slx_pkg::slx_dest_t d,
      input logic [15:0] v);
    put_reg = r;
    case (d)
      slx_pkg::SLX_D_FIRST:  put_reg.first_pair       = v;
      slx_pkg::SLX_D_SECOND: put_reg.second_pair      = v;
      slx_pkg::SLX_D_THIRD:  put_reg.third_pair       = v;
      slx_pkg::SLX_D_STACK:  put_reg.stack_pointer    = v;
      slx_pkg::SLX_D_IDX1:   put_reg.index_reg_first  = v;
      default:               put_reg.index_reg_second = v;
    endcase
  endfunction

  // a read cycle on the next clock
  function automatic slx_pkg::slx_mem_t rd_at(input logic [15:0] a);
    rd_at = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
  endfunction

  // a quiet bus: no strobe, address and data parked at zero
  function automatic slx_pkg::slx_mem_t mem_idle();
    mem_idle = '{rd: 1'b0, wr: 1'b0, addr: 16'h0000, wdata: 8'h00};
  endfunction

  // opcode with its pair field masked out, for the pair-coded forms
  function automatic logic [7:0] op_group(input logic [7:0] op);
    op_group = op & slx_pkg::MSK_LDI;
  endfunction

  // one of the three prefix bytes that open a second fetch
  function automatic logic is_prefix(input logic [7:0] op);
    is_prefix = (op == slx_pkg::PFX_IDX1) || (op == slx_pkg::PFX_IDX2) ||
                (op == slx_pkg::PFX_EXT);
  endfunction

  // next-state logic: every machine cycle counts its states in tcnt
  always_comb begin
    logic        last;
    logic [15:0] adr1;
    logic [15:0] word;
    logic [15:0] src;
    nxt_s = s_ff;
    last = 1'b0;
    adr1 = s_ff.oper + 16'h0001;
    word = {MEM_RDATA, s_ff.lo_byte};
    src = get_reg(s_ff.regs, s_ff.dest);
    // pulses last one cycle; flags pass through one cycle late
    nxt_s.done = 1'b0;
    nxt_s.illegal = 1'b0;
    nxt_s.flags = FLAGS_IN;
    // count down the states of the running machine cycle
    if (s_ff.busy) begin
      nxt_s.tcnt = s_ff.tcnt - 3'h1;
      last = (s_ff.tcnt == 3'h1);
    end
    case (s_ff.st)
      slx_pkg::SLX_FETCH: begin
        // idle: bus quiet until the core hands over an opcode address
        if (!s_ff.busy) begin
          nxt_s.mem = mem_idle();
          if (START) begin
            // opcode fetch at the core's address, four states
            nxt_s.busy = 1'b1;
            nxt_s.pc = PC_IN;
            nxt_s.prefix = 8'h00;
            nxt_s.tcnt = slx_pkg::T_FETCH;
            nxt_s.mem = rd_at(PC_IN);
          end
        end else if (last) begin
          nxt_s.pc = s_ff.pc + 16'h0001;
          nxt_s.kind = slx_pkg::SLX_K_NONE;
          nxt_s.dest = pair_dest(MEM_RDATA);
          // only one prefix is honoured; a second one decodes as opcode
          if (s_ff.prefix == 8'h00 && is_prefix(MEM_RDATA)) begin
            // prefix: second 4-state fetch
            nxt_s.prefix = MEM_RDATA;
            nxt_s.tcnt = slx_pkg::T_FETCH;
            nxt_s.mem = rd_at(s_ff.pc + 16'h0001);
          end else begin
            case (s_ff.prefix)
              // unprefixed: pair immediate, third pair to and from memory
              8'h00: begin
                if (op_group(MEM_RDATA) == slx_pkg::PAT_LDI)
                  nxt_s.kind = slx_pkg::SLX_K_IMM;
                else if (MEM_RDATA == slx_pkg::OPC_LDM_HL)
                  nxt_s.kind = slx_pkg::SLX_K_LOAD;
                else if (MEM_RDATA == slx_pkg::OPC_STM_HL)
                  nxt_s.kind = slx_pkg::SLX_K_STORE;
                if (MEM_RDATA == slx_pkg::OPC_LDM_HL ||
                    MEM_RDATA == slx_pkg::OPC_STM_HL)
                  nxt_s.dest = slx_pkg::SLX_D_THIRD;
              end
              // extended prefix: any pair to or from memory
              slx_pkg::PFX_EXT: begin
                if (op_group(MEM_RDATA) == slx_pkg::PAT_EXT_LD)
                  nxt_s.kind = slx_pkg::SLX_K_LOAD;
                else if (op_group(MEM_RDATA) == slx_pkg::PAT_EXT_ST)
                  nxt_s.kind = slx_pkg::SLX_K_STORE;
              end
              // index prefixes: the pair field no longer applies
              default: begin
                nxt_s.dest = (s_ff.prefix == slx_pkg::PFX_IDX1) ?
                             slx_pkg::SLX_D_IDX1 : slx_pkg::SLX_D_IDX2;
                if (MEM_RDATA == slx_pkg::OPC_LDI_IDX)
                  nxt_s.kind = slx_pkg::SLX_K_IMM;
                else if (MEM_RDATA == slx_pkg::OPC_LDM_HL)
                  nxt_s.kind = slx_pkg::SLX_K_LOAD;
                else if (MEM_RDATA == slx_pkg::OPC_STM_HL &&
                         s_ff.prefix == slx_pkg::PFX_IDX1)
                  nxt_s.kind = slx_pkg::SLX_K_STORE;
              end
            endcase
            if (nxt_s.kind == slx_pkg::SLX_K_NONE) begin
              // not in this group: hand back to the core at once
              nxt_s.busy = 1'b0;
              nxt_s.illegal = 1'b1;
              nxt_s.mem = mem_idle();
            end else begin
              nxt_s.st = slx_pkg::SLX_OPLO;
              nxt_s.tcnt = slx_pkg::T_MEM;
              nxt_s.mem = rd_at(s_ff.pc + 16'h0001);
            end
          end
        end
      end
      // first operand byte: low half of the word or address
      slx_pkg::SLX_OPLO: if (last) begin
        nxt_s.oper[7:0] = MEM_RDATA;
        nxt_s.pc = s_ff.pc + 16'h0001;
        nxt_s.st = slx_pkg::SLX_OPHI;
        nxt_s.tcnt = slx_pkg::T_MEM;
        nxt_s.mem = rd_at(s_ff.pc + 16'h0001);
      end

      // second operand byte: an immediate ends here, the rest go to memory
      slx_pkg::SLX_OPHI: if (last) begin
        nxt_s.oper[15:8] = MEM_RDATA;
        nxt_s.pc = s_ff.pc + 16'h0001;
        nxt_s.tcnt = slx_pkg::T_MEM;
        if (s_ff.kind == slx_pkg::SLX_K_IMM) begin
          nxt_s.regs = put_reg(s_ff.regs, s_ff.dest,
                               {MEM_RDATA, s_ff.oper[7:0]});
          nxt_s.st = slx_pkg::SLX_DONE;
          nxt_s.mem.rd = 1'b0;
        end else begin
          // write data set up with the address, held the whole cycle
          nxt_s.st = slx_pkg::SLX_MEMLO;
          nxt_s.mem.addr = {MEM_RDATA, s_ff.oper[7:0]};
          nxt_s.mem.rd = (s_ff.kind == slx_pkg::SLX_K_LOAD);
          nxt_s.mem.wr = (s_ff.kind == slx_pkg::SLX_K_STORE);
          nxt_s.mem.wdata = src[7:0];
        end
      end

      // low data byte at the operand address
      slx_pkg::SLX_MEMLO: if (last) begin
        nxt_s.lo_byte = MEM_RDATA;
        nxt_s.st = slx_pkg::SLX_MEMHI;
        nxt_s.tcnt = slx_pkg::T_MEM;
        nxt_s.mem.addr = adr1;
        nxt_s.mem.wdata = src[15:8];
      end

      // high byte at address plus one; a load writes the bank only now
      slx_pkg::SLX_MEMHI: if (last) begin
        if (s_ff.kind == slx_pkg::SLX_K_LOAD)
          nxt_s.regs = put_reg(s_ff.regs, s_ff.dest, word);
        nxt_s.st = slx_pkg::SLX_DONE;
        nxt_s.mem = mem_idle();
      end

      slx_pkg::SLX_DONE: begin
        // done pulses in the cycle after this one, two cycles after the last state
        nxt_s.done = 1'b1;
        nxt_s.busy = 1'b0;
        nxt_s.st = slx_pkg::SLX_FETCH;
        nxt_s.mem = mem_idle();
      end

      // a stray state code falls back to the fetch
      default: nxt_s.st = slx_pkg::SLX_FETCH;
    endcase
  end

  // state register, synchronous reset
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      // bank zeroed, bus idle, no pulse pending
      s_ff <= '0;
      s_ff.st <= slx_pkg::SLX_FETCH;
      s_ff.kind <= slx_pkg::SLX_K_NONE;
      s_ff.regs <= '{default: slx_pkg::WORD_RST};
      s_ff.flags <= slx_pkg::FLAGS_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // every output comes straight from the state register
  assign MEM_RD    = s_ff.mem.rd;
  assign MEM_WR    = s_ff.mem.wr;
  assign MEM_ADDR  = s_ff.mem.addr;
  assign MEM_WDATA = s_ff.mem.wdata;
  assign BUSY      = s_ff.busy;
  assign DONE      = s_ff.done;
  assign ILLEGAL   = s_ff.illegal;
  assign FLAGS_OUT = s_ff.flags;
  assign REGS      = s_ff.regs;
endmodule
`default_nettype wire

/* File: slx_exec_asserts.sv */
/*
  slx_exec_asserts: timing and data checks on the load executor ports.
  assumes one clock domain and a bind onto every slx_exec instance.
*/
`timescale 1ns/1ps
`default_nettype none
module slx_exec_asserts (
  input wire logic               MCLK,
  input wire logic               RESET,
  input wire logic               START,
  input wire logic [15:0]        PC_IN,
  input wire logic [7:0]         MEM_RDATA,
  input wire logic [7:0]         FLAGS_IN,
  input wire logic               MEM_RD,
  input wire logic               MEM_WR,
  input wire logic [15:0]        MEM_ADDR,
  input wire logic [7:0]         MEM_WDATA,
  input wire logic               BUSY,
  input wire logic               DONE,
  input wire logic               ILLEGAL,
  input wire logic [7:0]         FLAGS_OUT,
  input wire slx_pkg::slx_regs_t REGS
);
  logic [15:0] pc_q;

  // start address kept so the fetch check need not reach back in time
  always_ff @(posedge MCLK) begin
    if (START && !BUSY) pc_q <= PC_IN;
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);

  AST_FETCH: assert property (START && !BUSY |=>
    (MEM_RD && MEM_ADDR == pc_q)[*4] ##1 (!MEM_RD || MEM_ADDR != pc_q))
    else $error("opcode fetch not four states at start address");
  AST_FLAGS: assert property (!$past(RESET) |->
    FLAGS_OUT == $past(FLAGS_IN)) else $error("flag byte altered");
  AST_WR_STEP: assert property (MEM_WR && $past(MEM_WR) &&
    MEM_ADDR != $past(MEM_ADDR) |-> MEM_ADDR == $past(MEM_ADDR) + 16'h0001)
    else $error("high byte not written at address plus one");
  AST_WR_SPAN: assert property ($rose(MEM_WR) |->
    MEM_WR[*6] ##1 !MEM_WR ##1 DONE)
    else $error("store write cycles not two of three states");
  AST_WDATA_HOLD: assert property (MEM_WR && $past(MEM_WR) &&
    $stable(MEM_ADDR) |-> $stable(MEM_WDATA))
    else $error("write data moved inside a write cycle");
  AST_DONE_PULSE: assert property (DONE |=> !DONE)
    else $error("completion longer than one cycle");
  AST_DONE_IDLE: assert property (DONE |-> !BUSY && $past(BUSY))
    else $error("completion without a busy run before it");
  AST_REGS_AT_END: assert property (!$past(RESET) && $changed(REGS)
    |=> DONE) else $error("register bank changed away from completion");

  cover property (START && !BUSY);
  cover property (DONE);
  cover property (ILLEGAL);
  cover property ($rose(MEM_WR));
endmodule

bind slx_exec slx_exec_asserts u_asrt (.MCLK(MCLK), .RESET(RESET),
  .START(START), .PC_IN(PC_IN), .MEM_RDATA(MEM_RDATA), .FLAGS_IN(FLAGS_IN),
  .MEM_RD(MEM_RD), .MEM_WR(MEM_WR), .MEM_ADDR(MEM_ADDR),
  .MEM_WDATA(MEM_WDATA), .BUSY(BUSY), .DONE(DONE), .ILLEGAL(ILLEGAL),
  .FLAGS_OUT(FLAGS_OUT), .REGS(REGS));
`default_nettype wire

/* File: slx_mem_model.sv */
/*
  slx_mem_model: byte memory answering the executor's read/write cycles.
  assumes the bench preloads mem directly before each instruction.
*/
`timescale 1ns/1ps
`default_nettype none
module slx_mem_model (
  input  wire logic        clk,
  input  wire logic        rd,
  input  wire logic        wr,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  output logic      [7:0]  rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_ff = 8'h00;

  // idle bus shows the inverse of the last byte, so stale data never passes
  assign rdata = rd ? mem[addr] : ~last_ff;

  // plain always: the bench also writes mem when preloading
  always @(posedge clk) begin
    if (rd) last_ff <= mem[addr];
    if (wr) mem[addr] <= wdata;
  end
endmodule
`default_nettype wire

/* File: slx_exec_test.sv */
/*
  slx_exec_test: random and corner runs of the load group executor.
  assumes slx_mem_model on the memory port and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module slx_exec_test;
  logic               mclk, reset, start, mem_rd, mem_wr, busy, done, illegal;
  logic [15:0]        pc_in, mem_addr;
  logic [7:0]         flags_in, mem_rdata, mem_wdata, flags_out;
  slx_pkg::slx_regs_t regs, shadow;
  logic [31:0]        seed;
  int                 n_mismatch, check_count;

  slx_exec dut (.MCLK(mclk), .RESET(reset), .START(start), .PC_IN(pc_in),
    .MEM_RDATA(mem_rdata), .FLAGS_IN(flags_in), .MEM_RD(mem_rd),
    .MEM_WR(mem_wr), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata),
    .BUSY(busy), .DONE(done), .ILLEGAL(illegal), .FLAGS_OUT(flags_out),
    .REGS(regs));
  slx_mem_model u_mem (.clk(mclk), .rd(mem_rd), .wr(mem_wr),
    .addr(mem_addr), .wdata(mem_wdata), .rdata(mem_rdata));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // xorshift keeps every run repeatable from the fixed seed
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic slx_pkg::slx_regs_t upd(slx_pkg::slx_regs_t r, int d,
                                             logic [15:0] v);
    r[95 - 16 * d -: 16] = v;
    return r;
  endfunction
  task automatic chk(string what, logic [95:0] exp, logic [95:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // kind 0 immediate, 1 load, 2 store, 3 refused; st is the state count, one less for a refused opcode
  task automatic exec(logic [7:0] pfx, logic [7:0] op, int st, int kind,
                      int d, logic [15:0] nn);
    logic [15:0] pc, dat;
    logic [7:0]  fl;
    int          n;
    pc = 16'(rnd());
    pc[15] = 1'b0; // code below 4000, data above 8000: no overlap
    pc[14] = 1'b0;
    pc[8] = 1'b1;
    nn[15] = 1'b1;
    dat = 16'(rnd());
    n = (pfx != 8'h00) ? 1 : 0;
    if (n == 1) u_mem.mem[pc] = pfx;
    u_mem.mem[pc + n] = op;
    u_mem.mem[pc + n + 1] = nn[7:0];
    u_mem.mem[pc + n + 2] = nn[15:8];
    if (kind == 1) begin
      u_mem.mem[nn] = dat[7:0];
      u_mem.mem[nn + 16'h0001] = dat[15:8];
    end
    @(posedge mclk);
    start    <= 1'b1;
    pc_in    <= pc;
    flags_in <= 8'(rnd());
    @(posedge mclk);
    start <= 1'b0;
    n = 0;
    while (done !== 1'b1 && illegal !== 1'b1 && n < 40) begin
      @(posedge mclk);
      fl = flags_in; // value the design takes at this edge
      flags_in <= 8'(rnd());
      #1;
      n++;
    end
    chk("cycles", 96'(st + 1), 96'(n));
    chk("refused", 96'(kind == 3), 96'(illegal));
    chk("flags", 96'(fl), 96'(flags_out));
    chk("busy", 96'(1'b0), 96'(busy));
    if (kind < 2) shadow = upd(shadow, d, kind == 0 ? nn : dat);
    chk("regs", shadow, regs);
    dat = shadow[95 - 16 * d -: 16];
    if (kind == 2)
      chk("stored", 96'(dat), 96'({u_mem.mem[nn + 16'h0001], u_mem.mem[nn]}));
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    conclude();
  end

  initial begin
    seed = 32'h0000005B;
    n_mismatch = 0;
    check_count = 0;
    shadow = '0;
    reset = 1'b1;
    start = 1'b0;
    pc_in = 16'h0000;
    flags_in = 8'h00;
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    repeat (3) begin
      for (int d = 0; d < 4; d++) begin
        exec(8'h00, 8'h01 | 8'(d << 4), 10, 0, d, 16'(rnd()));
        exec(8'hED, 8'h4B | 8'(d << 4), 20, 1, d, 16'(rnd()));
        exec(8'hED, 8'h43 | 8'(d << 4), 20, 2, d, 16'(rnd()));
      end
      exec(8'hDD, 8'h21, 14, 0, 4, 16'(rnd()));
      exec(8'hFD, 8'h21, 14, 0, 5, 16'(rnd()));
      exec(8'h00, 8'h2A, 16, 1, 2, 16'(rnd()));
      exec(8'hDD, 8'h2A, 20, 1, 4, 16'(rnd()));
      exec(8'hFD, 8'h2A, 20, 1, 5, 16'(rnd()));
      exec(8'h00, 8'h22, 16, 2, 2, 16'(rnd()));
      exec(8'hDD, 8'h22, 20, 2, 4, 16'(rnd()));
    end
    // top of memory: the high byte wraps round to address 0000
    exec(8'h00, 8'h2A, 16, 1, 2, 16'hFFFF);
    exec(8'hDD, 8'h22, 20, 2, 4, 16'hFFFF);
    // opcodes outside the group, flagged at the last fetch state
    exec(8'h00, 8'h00, 3, 3, 0, 16'h8000);
    exec(8'hFD, 8'h22, 7, 3, 0, 16'h8000);
    conclude();
  end
endmodule
`default_nettype wire
